// >>> rtl/rbs_pkg.sv
// Package of the reset and boot-strap block: register map, field positions,
// reset values, timing constants, phase enumeration and state record.
// Assumes one 100 MHz system clock and AHB-Lite word access to registers.
package rbs_pkg;

	// Timing
	localparam int CLK_PERIOD_NS        = 10;
	localparam int SETTLE_NS            = 100;
	localparam int SETTLE_CYC_DEF       = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_TIMEOUT_NS      = 61035;
	localparam int SLOW_TIMEOUT_CYC_DEF = SLOW_TIMEOUT_NS / CLK_PERIOD_NS;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_RST_CNT  = 8'h08;
	localparam logic [7:0] REG_SLOW_PER = 8'h0c;

	// Control bits
	localparam int CTRL_BOOT_DONE = 0;
	localparam int CTRL_LP_REQ    = 1;
	localparam int CTRL_REBOOT    = 2;

	// Status bits
	localparam int STAT_FLASH_1V8   = 0;
	localparam int STAT_BOOT_LO     = 1;
	localparam int STAT_BOOT_HI     = 2;
	localparam int STAT_DBG_EN      = 3;
	localparam int STAT_SDIO_IN_R   = 4;
	localparam int STAT_SDIO_OUT_R  = 5;
	localparam int STAT_BOOT_RSVD   = 6;
	localparam int STAT_SLOW_OK     = 7;
	localparam int STAT_LP_ACTIVE   = 8;
	localparam int STAT_CFG_VALID   = 9;

	// Strap vector positions and synchroniser layout
	localparam int STRAP_W      = 5;
	localparam int STRAP_FLASH  = 0;
	localparam int STRAP_BOOT_LO = 1;
	localparam int STRAP_BOOT_HI = 2;
	localparam int STRAP_DBG_SDIO = 3;
	localparam int STRAP_SDIO_LO = 4;
	localparam int SYNC_RST     = 5;
	localparam int SYNC_SLOW    = 6;
	localparam int SYNC_W       = 7;

	// Internal pull defaults per strap bit
	localparam logic [STRAP_W-1:0] PULL_UP_DEF = 5'h1d;
	localparam logic [STRAP_W-1:0] PULL_DN_DEF = 5'h02;

	// Boot codes
	localparam logic [1:0] BOOT_DOWNLOAD = 2'h0;
	localparam logic [1:0] BOOT_RESERVED = 2'h1;

	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		ST_HOLD  = 2'b00,
		ST_LATCH = 2'b01,
		ST_RUN   = 2'b10
	} rbs_phase_type;

	typedef struct packed {
		rbs_phase_type      st;
		logic [15:0]        settle;
		logic               core_rst_n;
		logic               low_power;
		logic               cfg_valid;
		logic [STRAP_W-1:0] straps;
		logic               flash_1v8;
		logic               boot_download;
		logic               boot_normal;
		logic               boot_reserved;
		logic               dbg_print_en;
		logic               sdio_in_rise;
		logic               sdio_out_rise;
		logic               boot_done;
		logic               lp_req;
		logic               lp_active;
		logic [15:0]        rst_cnt;
		logic               slow_prev;
		logic               slow_ok;
		logic [15:0]        slow_cnt;
		logic [15:0]        slow_period;
		logic               serial_tx;
		logic               wr_pend;
		logic [7:0]         wr_addr;
		logic [31:0]        hrdata;
		logic               hreadyout;
		logic               reset_pullup_en;
		logic [STRAP_W-1:0] pull_up;
		logic [STRAP_W-1:0] pull_dn;
	} rbs_state_type;

endpackage : rbs_pkg

// >>> rtl/rbs_sync_if.sv
// Carrier between the top module and its pin synchroniser.
// Assumes both ends sit on clk_sys.
`timescale 1ns/100ps
interface rbs_sync_if #(parameter int W = 1);
	logic [W-1:0] async_in;
	logic [W-1:0] sync_out;

	modport sync_side (input async_in, output sync_out);
	modport user_side (output async_in, input sync_out);
endinterface : rbs_sync_if

// >>> rtl/rbs_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous pin levels; output is a filtered register on clk_sys.
`timescale 1ns/100ps
module rbs_sync #(
	parameter int W = 1
) (
	input wire logic   clk_sys,
	input wire logic   rstn,
	rbs_sync_if.sync_side sif
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] flt;
	} rbs_sync_state_type;

	rbs_sync_state_type q_ff;
	rbs_sync_state_type nxt_q;

	if (W < 1) begin : g_chk
		$error("rbs_sync width must be at least one");
	end

	always_comb begin
		nxt_q    = q_ff;
		nxt_q.s1 = sif.async_in;
		nxt_q.s2 = q_ff.s1;
		nxt_q.s3 = q_ff.s2;
		// Stage one feeds stage two only; the filter looks at two and three
		for (int i = 0; i < W; i++) begin
			if (q_ff.s2[i] == q_ff.s3[i]) begin
				nxt_q.flt[i] = q_ff.s2[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign sif.sync_out = q_ff.flt;

	AST_SYNC_AGREE: assert property (@(posedge clk_sys) disable iff (!rstn)
		(q_ff.flt != $past(q_ff.flt)) |-> ($past(q_ff.s2) == $past(q_ff.s3)))
		else $error("filtered level changed without stage agreement");

endmodule : rbs_sync

// >>> rtl/rbs_reset_strap.sv
// Reset and boot-strap configuration block: pin reset sequencing, strap
// capture and decode, boot serial gating, slow clock monitor, AHB-Lite regs.
// Assumes asynchronous pins, zero-wait AHB-Lite slave on clk_sys, rstn async.
//
// Behaviour
// RULE_01 - Reset pin low forces a full hardware reset and reboot.
// RULE_02 - Internal pull-up keeps reset pin high when undriven.
// RULE_03 - Board drives reset pin only open-drain or by switch.
// RULE_04 - Device stays in minimum-power state while reset pin is low.
// RULE_05 - Board straps each boot pin with pull resistor during boot.
// RULE_06 - Flash supply strap: 0 gives 3.3 V, 1 gives 1.8 V; pull-up default.
// RULE_07 - Boot code 00 download, 10 and 11 normal flash boot; default 10.
// RULE_08 - Board never presents reserved boot code 01.
// RULE_09 - Debug strap 0 silences primary serial transmit during boot; 1 default.
// RULE_10 - Board may ground debug strap to suppress boot printouts.
// RULE_11 - SDIO timing strap picks sampling and launch edges; 11 default.
// RULE_12 - Board supplies 32.768 kHz slow clock when low-power modes used.
// RULE_13 - Strap pins hold their levels throughout start-up.
// RULE_14 - Straps latched once at reset release, held until next reset.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module rbs_reset_strap
	import rbs_pkg::*;
#(
	parameter int SETTLE_CYC       = rbs_pkg::SETTLE_CYC_DEF,
	parameter int SLOW_TIMEOUT_CYC = rbs_pkg::SLOW_TIMEOUT_CYC_DEF
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	input  wire logic                        pin_reset_n_in,
	input  wire logic                        pin_flash_vsel_in,
	input  wire logic [1:0]                  pin_boot_mode_in,
	input  wire logic                        pin_dbg_sdio_in,
	input  wire logic                        pin_sdio_edge_in,
	input  wire logic                        slow_clock_in,
	input  wire logic                        serial_tx_raw,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	output logic                             reset_pullup_en,
	output logic      [rbs_pkg::STRAP_W-1:0] strap_pullup_en,
	output logic      [rbs_pkg::STRAP_W-1:0] strap_pulldn_en,
	output logic                             core_rst_n,
	output logic                             low_power,
	output logic                             cfg_valid,
	output logic                             flash_1v8,
	output logic                             boot_download,
	output logic                             boot_normal,
	output logic                             dbg_print_en,
	output logic                             sdio_in_rise,
	output logic                             sdio_out_rise,
	output logic                             lp_active,
	output logic                             primary_serial_port_tx
);
	rbs_state_type q_ff;
	rbs_state_type nxt_q;
	logic          rst_hi;
	logic          slow_now;
	logic          reboot;
	logic [1:0]    boot_code;
	logic [STRAP_W-1:0] straps_now;

	if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_chk_settle
		$error("SETTLE_CYC out of range");
	end
	if (SLOW_TIMEOUT_CYC < 1 || SLOW_TIMEOUT_CYC > 65534) begin : g_chk_slow
		$error("SLOW_TIMEOUT_CYC out of range");
	end

	rbs_sync_if #(.W(SYNC_W)) sif ();

	assign sif.async_in = {slow_clock_in, pin_reset_n_in, pin_sdio_edge_in, pin_dbg_sdio_in,
		pin_boot_mode_in[1], pin_boot_mode_in[0], pin_flash_vsel_in};

	rbs_sync #(.W(SYNC_W)) u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.sif     (sif)
	);

	assign rst_hi     = sif.sync_out[SYNC_RST];
	assign slow_now   = sif.sync_out[SYNC_SLOW];
	assign straps_now = sif.sync_out[STRAP_W-1:0];
	assign boot_code  = {straps_now[STRAP_BOOT_HI], straps_now[STRAP_BOOT_LO]};

	function automatic logic [31:0] read_word(input logic [7:0] a, input rbs_state_type s);
		logic [31:0] r;
		r = '0;
		unique case (a)
			REG_CTRL: begin
				r[CTRL_BOOT_DONE] = s.boot_done;
				r[CTRL_LP_REQ]    = s.lp_req;
			end
			REG_STATUS: begin
				r[STAT_FLASH_1V8]  = s.flash_1v8;
				r[STAT_BOOT_LO]    = s.straps[STRAP_BOOT_LO];
				r[STAT_BOOT_HI]    = s.straps[STRAP_BOOT_HI];
				r[STAT_DBG_EN]     = s.dbg_print_en;
				r[STAT_SDIO_IN_R]  = s.sdio_in_rise;
				r[STAT_SDIO_OUT_R] = s.sdio_out_rise;
				r[STAT_BOOT_RSVD]  = s.boot_reserved;
				r[STAT_SLOW_OK]    = s.slow_ok;
				r[STAT_LP_ACTIVE]  = s.lp_active;
				r[STAT_CFG_VALID]  = s.cfg_valid;
			end
			REG_RST_CNT:  r[15:0] = s.rst_cnt;
			REG_SLOW_PER: r[15:0] = s.slow_period;
			default:      r = '0;
		endcase
		return r;
	endfunction : read_word

	always_comb begin
		nxt_q                 = q_ff;
		nxt_q.pull_up         = PULL_UP_DEF;
		nxt_q.pull_dn         = PULL_DN_DEF;
		nxt_q.reset_pullup_en = 1'b1; // [RULE_02]
		nxt_q.hreadyout       = 1'b1;
		reboot = q_ff.wr_pend && (q_ff.wr_addr == REG_CTRL) && hwdata[CTRL_REBOOT];

		unique case (q_ff.st)
			ST_HOLD: begin
				nxt_q.core_rst_n = 1'b0;
				nxt_q.low_power  = 1'b1; // [RULE_04]
				nxt_q.cfg_valid  = 1'b0;
				if (!rst_hi) begin
					nxt_q.settle = '0;
				end else if (q_ff.settle == 16'(SETTLE_CYC - 1)) begin
					nxt_q.st = ST_LATCH;
				end else begin
					nxt_q.settle = q_ff.settle + 16'h0001;
				end
			end
			ST_LATCH: begin
				// Single capture point; straps ignored from here on
				nxt_q.straps        = straps_now; // [RULE_14]
				nxt_q.flash_1v8     = straps_now[STRAP_FLASH]; // [RULE_06]
				nxt_q.boot_download = (boot_code == BOOT_DOWNLOAD); // [RULE_07]
				nxt_q.boot_normal   = boot_code[1]; // [RULE_07]
				// Reserved code boots neither way, so a bad strap stays visible
				nxt_q.boot_reserved = (boot_code == BOOT_RESERVED);
				nxt_q.dbg_print_en  = straps_now[STRAP_DBG_SDIO]; // [RULE_09]
				nxt_q.sdio_in_rise  = straps_now[STRAP_DBG_SDIO]; // [RULE_11]
				nxt_q.sdio_out_rise = straps_now[STRAP_SDIO_LO]; // [RULE_11]
				nxt_q.cfg_valid     = 1'b1;
				nxt_q.core_rst_n    = 1'b1;
				nxt_q.low_power     = 1'b0;
				nxt_q.st            = ST_RUN;
			end
			ST_RUN: begin
				if (q_ff.wr_pend && (q_ff.wr_addr == REG_CTRL)) begin
					nxt_q.boot_done = hwdata[CTRL_BOOT_DONE];
					nxt_q.lp_req    = hwdata[CTRL_LP_REQ];
				end
			end
			default: nxt_q.st = ST_HOLD;
		endcase

		// Pin low or software reboot restarts the whole sequence
		if ((q_ff.st != ST_HOLD) && (!rst_hi || reboot)) begin
			nxt_q.st         = ST_HOLD; // [RULE_01]
			nxt_q.settle     = '0;
			nxt_q.core_rst_n = 1'b0; // [RULE_01]
			nxt_q.low_power  = 1'b1; // [RULE_04]
			nxt_q.cfg_valid  = 1'b0;
			nxt_q.boot_done  = 1'b0;
			nxt_q.lp_req     = 1'b0;
			nxt_q.rst_cnt    = q_ff.rst_cnt + 16'h0001;
		end

		// Slow clock monitor: period in system cycles, lost after timeout
		nxt_q.slow_prev = slow_now;
		if (slow_now && !q_ff.slow_prev) begin
			nxt_q.slow_period = q_ff.slow_cnt;
			// The edge cycle is already the first cycle of the next period
			nxt_q.slow_cnt    = 16'h0001;
			nxt_q.slow_ok     = 1'b1;
		end else begin
			if (q_ff.slow_cnt != 16'hffff) begin
				nxt_q.slow_cnt = q_ff.slow_cnt + 16'h0001;
			end
			if (q_ff.slow_cnt >= 16'(SLOW_TIMEOUT_CYC)) begin
				nxt_q.slow_ok = 1'b0;
			end
		end
		// Low power is refused without the external slow clock
		nxt_q.lp_active = q_ff.lp_req && q_ff.slow_ok && (q_ff.st == ST_RUN); // [RULE_12]

		// Transmit idles high in reset and while boot printouts are silenced
		if ((q_ff.st == ST_RUN) && (q_ff.dbg_print_en || q_ff.boot_done)) begin
			nxt_q.serial_tx = serial_tx_raw; // [RULE_09]
		end else begin
			nxt_q.serial_tx = 1'b1; // [RULE_09]
		end

		nxt_q.wr_pend = 1'b0;
		if (hsel && htrans[1] && hready) begin
			if (hwrite) begin
				nxt_q.wr_pend = (hsize == HSIZE_WORD);
				nxt_q.wr_addr = haddr[7:0];
			end else begin
				nxt_q.hrdata = read_word(haddr[7:0], q_ff);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q_ff                 <= '0;
			q_ff.low_power       <= 1'b1;
			q_ff.serial_tx       <= 1'b1;
			q_ff.hreadyout       <= 1'b1;
			q_ff.reset_pullup_en <= 1'b1;
			q_ff.pull_up         <= PULL_UP_DEF;
			q_ff.pull_dn         <= PULL_DN_DEF;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign hrdata                 = q_ff.hrdata;
	assign hreadyout              = q_ff.hreadyout;
	assign hresp                  = 1'b0;
	assign reset_pullup_en        = q_ff.reset_pullup_en;
	assign strap_pullup_en        = q_ff.pull_up;
	assign strap_pulldn_en        = q_ff.pull_dn;
	assign core_rst_n             = q_ff.core_rst_n;
	assign low_power              = q_ff.low_power;
	assign cfg_valid              = q_ff.cfg_valid;
	assign flash_1v8              = q_ff.flash_1v8;
	assign boot_download          = q_ff.boot_download;
	assign boot_normal            = q_ff.boot_normal;
	assign dbg_print_en           = q_ff.dbg_print_en;
	assign sdio_in_rise           = q_ff.sdio_in_rise;
	assign sdio_out_rise          = q_ff.sdio_out_rise;
	assign lp_active              = q_ff.lp_active;
	assign primary_serial_port_tx = q_ff.serial_tx;

	// Assertion helper: cycles spent with the pin released and no valid configuration.
	// A counter rather than a long delay range keeps the property cheap for the tools.
	logic [16:0] rel_wait_ff;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rel_wait_ff <= '0;
		end else if (cfg_valid || !rst_hi) begin
			rel_wait_ff <= '0;
		end else if (rel_wait_ff != 17'h1ffff) begin
			rel_wait_ff <= rel_wait_ff + 17'h00001;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_PIN_RESET: assert property (!rst_hi |=> (q_ff.st == ST_HOLD) && !core_rst_n) // [RULE_01]
		else $error("reset pin low did not hold the core in reset");
	AST_PULLUP: assert property (reset_pullup_en && strap_pullup_en == PULL_UP_DEF) // [RULE_02]
		else $error("internal pull-up not enabled");
	AST_MIN_POWER: assert property ((q_ff.st == ST_HOLD) |-> low_power && !cfg_valid) // [RULE_04]
		else $error("not in minimum power while held in reset");
	AST_FLASH_SEL: assert property ((q_ff.st == ST_LATCH) |=> // [RULE_06]
		flash_1v8 == $past(straps_now[STRAP_FLASH]))
		else $error("flash supply selection does not follow strap");
	AST_BOOT_DEC: assert property (cfg_valid |-> // [RULE_07]
		boot_download == (q_ff.straps[STRAP_BOOT_HI:STRAP_BOOT_LO] == 2'h0) &&
		boot_normal == q_ff.straps[STRAP_BOOT_HI])
		else $error("boot mode decode wrong");
	AST_DBG_SILENT: assert property (cfg_valid && !dbg_print_en && !q_ff.boot_done // [RULE_09]
		|=> primary_serial_port_tx)
		else $error("serial transmit toggled while silenced");
	AST_SDIO_EDGE: assert property (cfg_valid |-> // [RULE_11]
		sdio_in_rise == q_ff.straps[STRAP_DBG_SDIO] &&
		sdio_out_rise == q_ff.straps[STRAP_SDIO_LO])
		else $error("SDIO edge selection wrong");
	AST_CFG_HOLD: assert property ((q_ff.st == ST_RUN) && $past(q_ff.st == ST_RUN) |-> // [RULE_14]
		$stable(q_ff.straps) && $stable(flash_1v8) && $stable(boot_download))
		else $error("latched configuration changed outside reset");
	// Settle count, one latch cycle and one cycle of register lag
	AST_RELEASE: assert property (rel_wait_ff <= 17'(SETTLE_CYC + 2)) // [RULE_14]
		else $error("configuration not latched after release");
	AST_RUN_UP: assert property (cfg_valid |-> core_rst_n && !low_power) // [RULE_01]
		else $error("core held in reset with a valid configuration");
	AST_TX_PASS: assert property (cfg_valid && dbg_print_en |=> // [RULE_09]
		primary_serial_port_tx == $past(serial_tx_raw))
		else $error("serial transmit blocked while printouts enabled");
	AST_LP_SLOW: assert property (lp_active |-> // [RULE_12]
		$past(q_ff.slow_ok) && $past(q_ff.lp_req))
		else $error("low power entered without the slow clock");

	COV_DOWNLOAD: cover property ($rose(cfg_valid) && boot_download);
	COV_RESERVED: cover property ($rose(cfg_valid) && q_ff.boot_reserved);
	COV_LOW_POWER: cover property ($rose(lp_active));
	COV_REBOOT: cover property (cfg_valid ##1 !cfg_valid ##[1:100] $rose(cfg_valid));
	COV_SILENT: cover property ($rose(cfg_valid) && !dbg_print_en);

endmodule : rbs_reset_strap

// >>> verification/rbs_board_model.sv
// Board model: strap resistors, open-drain reset switch and slow clock source.
// Assumes its controls change right after rising edges of clk_sys.
`timescale 1ns/100ps
module rbs_board_model
	import rbs_pkg::*;
#(
	parameter int SLOW_HALF = 8
) (
	input  wire logic                        clk_sys,
	input  wire logic                        press,
	input  wire logic [rbs_pkg::STRAP_W-1:0] fit,
	input  wire logic [rbs_pkg::STRAP_W-1:0] fit_val,
	input  wire logic                        slow_run,
	input  wire logic                        reset_pullup_en,
	input  wire logic [rbs_pkg::STRAP_W-1:0] strap_pullup_en,
	input  wire logic [rbs_pkg::STRAP_W-1:0] strap_pulldn_en,
	output logic                             pin_reset_n_in,
	output logic                             pin_flash_vsel_in,
	output logic      [1:0]                  pin_boot_mode_in,
	output logic                             pin_dbg_sdio_in,
	output logic                             pin_sdio_edge_in,
	output logic                             slow_clock_in
);
	logic [STRAP_W-1:0] lvl;
	logic               flip_ff = 1'b0;
	int                 slow_cnt;

	// An undriven line toggles so that a lost pull cannot pass by luck
	always_ff @(posedge clk_sys) begin
		flip_ff <= ~flip_ff;
	end

	// Open drain only: pulled low by the switch, never driven high
	assign pin_reset_n_in = press ? 1'b0 : (reset_pullup_en ? 1'b1 : flip_ff);

	// Fitted board resistor beats the weak internal pull
	always_comb begin
		for (int i = 0; i < STRAP_W; i++) begin
			if (fit[i])
				lvl[i] = fit_val[i];
			else if (strap_pullup_en[i])
				lvl[i] = 1'b1;
			else if (strap_pulldn_en[i])
				lvl[i] = 1'b0;
			else
				lvl[i] = flip_ff;
		end
	end

	// Code 01 appears only where the bench commands it
	assign pin_flash_vsel_in = lvl[STRAP_FLASH];
	assign pin_boot_mode_in  = {lvl[STRAP_BOOT_HI], lvl[STRAP_BOOT_LO]};
	assign pin_dbg_sdio_in   = lvl[STRAP_DBG_SDIO];
	assign pin_sdio_edge_in  = lvl[STRAP_SDIO_LO];

	// Slow clock stands still while not in use
	always_ff @(posedge clk_sys) begin
		if (!slow_run) begin
			slow_cnt <= 0;
			slow_clock_in <= 1'b0;
		end else if (slow_cnt == SLOW_HALF - 1) begin
			slow_cnt <= 0;
			slow_clock_in <= ~slow_clock_in;
		end else begin
			slow_cnt <= slow_cnt + 1;
		end
	end
endmodule : rbs_board_model

// >>> verification/rbs_reset_strap_tb_top.sv
// Testbench: AHB-Lite master tasks, board model at the pins; checks strap
// decode, pin reset, serial gating and the slow clock monitor.
// Assumes a zero-wait slave and shortened settle and timeout counts.
`timescale 1ns/100ps
module rbs_reset_strap_tb_top;
	import rbs_pkg::*;

	localparam int SETTLE    = 2;
	localparam int SLOW_TO   = 50;
	localparam int SLOW_HALF = 8;

	logic         clk_sys, rstn, press, slow_run, serial_tx_raw;
	logic [4:0]   fit, fit_val, strap_pullup_en, strap_pulldn_en;
	logic         pin_reset_n_in, pin_flash_vsel_in, pin_dbg_sdio_in, pin_sdio_edge_in;
	logic [1:0]   pin_boot_mode_in, htrans;
	logic         slow_clock_in, hsel, hwrite, hreadyout, hresp, reset_pullup_en;
	logic [31:0]  haddr, hwdata, hrdata, rd;
	logic [2:0]   hsize;
	logic         core_rst_n, low_power, cfg_valid, flash_1v8, boot_download, boot_normal;
	logic         dbg_print_en, sdio_in_rise, sdio_out_rise, lp_active, primary_serial_port_tx;
	logic [4:0]   lv;
	wire logic    hready;
	int           err_total, compares;
	logic [4:0]   cfit[4] = '{5'h1f, 5'h1f, 5'h1f, 5'h00};
	logic [4:0]   cval[4] = '{5'h00, 5'h17, 5'h0b, 5'h00};

	assign hready = hreadyout;

	rbs_reset_strap #(.SETTLE_CYC(SETTLE), .SLOW_TIMEOUT_CYC(SLOW_TO)) dut (
		.clk_sys(clk_sys), .rstn(rstn), .pin_reset_n_in(pin_reset_n_in),
		.pin_flash_vsel_in(pin_flash_vsel_in), .pin_boot_mode_in(pin_boot_mode_in),
		.pin_dbg_sdio_in(pin_dbg_sdio_in), .pin_sdio_edge_in(pin_sdio_edge_in),
		.slow_clock_in(slow_clock_in), .serial_tx_raw(serial_tx_raw), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.reset_pullup_en(reset_pullup_en), .strap_pullup_en(strap_pullup_en),
		.strap_pulldn_en(strap_pulldn_en), .core_rst_n(core_rst_n), .low_power(low_power),
		.cfg_valid(cfg_valid), .flash_1v8(flash_1v8), .boot_download(boot_download),
		.boot_normal(boot_normal), .dbg_print_en(dbg_print_en), .sdio_in_rise(sdio_in_rise),
		.sdio_out_rise(sdio_out_rise), .lp_active(lp_active),
		.primary_serial_port_tx(primary_serial_port_tx));

	rbs_board_model #(.SLOW_HALF(SLOW_HALF)) board (
		.clk_sys(clk_sys), .press(press), .fit(fit), .fit_val(fit_val), .slow_run(slow_run),
		.reset_pullup_en(reset_pullup_en), .strap_pullup_en(strap_pullup_en),
		.strap_pulldn_en(strap_pulldn_en), .pin_reset_n_in(pin_reset_n_in),
		.pin_flash_vsel_in(pin_flash_vsel_in), .pin_boot_mode_in(pin_boot_mode_in),
		.pin_dbg_sdio_in(pin_dbg_sdio_in), .pin_sdio_edge_in(pin_sdio_edge_in),
		.slow_clock_in(slow_clock_in));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	// Single word transfer; waits on hready, no cycle count assumed
	task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		hsize  <= HSIZE_WORD;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rdat = hrdata;
	endtask : ahb_xfer

	task automatic wait_cfg();
		int n;
		n = 0;
		while (cfg_valid !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk_bit(cfg_valid, 1'b1);
	endtask : wait_cfg

	task automatic pin_reset(input logic [4:0] f, input logic [4:0] v);
		@(posedge clk_sys);
		press   <= 1'b1;
		fit     <= f;
		fit_val <= v;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_bit(low_power, 1'b1);
		chk_bit(core_rst_n, 1'b0);
		chk_bit(cfg_valid, 1'b0);
		@(posedge clk_sys);
		press <= 1'b0;
		wait_cfg();
	endtask : pin_reset

	task automatic chk_cfg(input logic [4:0] v);
		logic [31:0] st;
		chk_bit(flash_1v8, v[0]);
		chk_bit(boot_download, v[2:1] == 2'b00);
		chk_bit(boot_normal, v[2]);
		chk_bit(dbg_print_en, v[3]);
		chk_bit(sdio_in_rise, v[3]);
		chk_bit(sdio_out_rise, v[4]);
		ahb_xfer(1'b0, {24'h0, REG_STATUS}, 32'h0, st);
		chk_word(st, {22'h0, 1'b1, 2'b00, v[2:1] == 2'b01, v[4], v[3], v[3:0]});
	endtask : chk_cfg

	// Raw transmit must appear one cycle later only when allowed
	task automatic tx_chk(input logic pass);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys);
			serial_tx_raw <= i[0];
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk_bit(primary_serial_port_tx, pass ? i[0] : 1'b1);
		end
	endtask : tx_chk

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		$display("Error t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
		conclude();
	end

	initial begin
		rstn = 1'b0;
		press = 1'b0;
		fit = 5'h00;
		fit_val = 5'h00;
		slow_run = 1'b0;
		serial_tx_raw = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		err_total = 0;
		compares = 0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		wait_cfg();
		chk_bit(reset_pullup_en, 1'b1);
		chk_bit(hresp, 1'b0);
		chk_word({27'h0, strap_pullup_en}, {27'h0, PULL_UP_DEF});
		chk_cfg(5'h1d);
		ahb_xfer(1'b0, 32'h10, 32'h0, rd);
		chk_word(rd, 32'h0);
		$display("test defaults done");
		for (int k = 0; k < 4; k++) begin
			pin_reset(cfit[k], cval[k]);
			lv = (cfit[k] & cval[k]) | (~cfit[k] & PULL_UP_DEF);
			chk_cfg(lv);
			@(posedge clk_sys);
			fit <= 5'h1f;
			fit_val <= ~lv;
			repeat (10) @(posedge clk_sys);
			chk_cfg(lv);
			tx_chk(lv[3]);
			if (!lv[3]) begin
				ahb_xfer(1'b1, {24'h0, REG_CTRL}, 32'h1, rd);
				tx_chk(1'b1);
			end
		end
		ahb_xfer(1'b0, {24'h0, REG_RST_CNT}, 32'h0, rd);
		chk_word(rd, 32'h4);
		$display("test strap table done");
		@(posedge clk_sys);
		slow_run <= 1'b1;
		ahb_xfer(1'b1, {24'h0, REG_CTRL}, 32'h2, rd);
		repeat (80) @(posedge clk_sys);
		chk_bit(lp_active, 1'b1);
		ahb_xfer(1'b0, {24'h0, REG_SLOW_PER}, 32'h0, rd);
		chk_word(rd, 2 * SLOW_HALF);
		@(posedge clk_sys);
		slow_run <= 1'b0;
		repeat (SLOW_TO + 20) @(posedge clk_sys);
		chk_bit(lp_active, 1'b0);
		$display("test slow clock done");
		conclude();
	end
endmodule : rbs_reset_strap_tb_top
